// [hdl/cbu_branch_unit.sv]
// Conditional branch unit: decode, compare-against-zero, next program counter and latency
// Contract
// - Decode opcodes, delay, condition, register, offset fields
// - Greater condition branches when value above zero
// - Less-or-equal branches when value at most zero
// - Less condition branches when value below zero
// - Not-equal branches when value is nonzero
// - Register form target is pc plus offset register
// - Immediate form target is pc plus extended immediate
// - Not taken advances pc by four
// - Delay flag set selects delayed variant
// - Delayed branch lets slot instruction complete
// - Undelayed branch squashes the following instruction
// - Immediate sign-extended from sixteen to thirty-two bits
// - Preceding prefix supplies the full immediate; the code takes only the upper half from the prefix, the low half from the word
// - Untaken branch occupies one cycle
// - Taken delayed branch takes two cycles
// - Taken undelayed branch takes three cycles
// - Correctly predicted immediate branch takes one cycle
// - Mispredict at area setting zero takes three
// - Mispredict at area setting two takes seven-nine
`timescale 1ns/100ps
module cbu_branch_unit
   import cbu_pkg::*;
#(
   parameter int AREA_OPTIMIZATION_SETTING = 0,
   parameter logic [3:0] DEEP_MISPRED_CYCLES = CBU_LAT_MISPRED_AREA2_MAX
) (
   input wire logic clk_sys, // Core clock
   input wire logic reset, // Asynchronous reset, active high
   input wire logic instr_valid, // Instruction presented for issue
   input wire logic [31:0] instr_word, // Instruction word, bit 0 is the msb
   input wire logic [31:0] pc_current, // Address of this instruction
   input wire logic [31:0] tested_register, // Value of the tested register
   input wire logic [31:0] offset_register, // Value of the offset register
   input wire logic prefix_valid, // Immediate prefix directly precedes
   input wire logic [15:0] prefix_high, // Upper immediate half from prefix
   input wire logic pred_valid, // Predictor gave a forecast
   input wire logic pred_taken, // Forecast outcome
   output logic instr_ready, // Unit can take an instruction
   output logic is_branch, // Last taken instruction was a branch
   output logic branch_taken, // Condition held
   output logic [31:0] pc_next, // Next program counter
   output logic pc_load, // Pulse: load pc_next
   output logic slot_execute, // Delay slot instruction may complete
   output logic slot_squash, // Following instruction is discarded
   output logic [4:0] tested_index, // Tested register number
   output logic [4:0] offset_index, // Offset register number
   output logic mispredict, // Pulse: prediction was wrong
   output logic [3:0] branch_cycles // Cycles the branch occupies
);
   cbu_state_e state_reg, state_next;
   logic [3:0] wait_reg, wait_next;
   logic ready_reg, ready_next;
   logic is_br_reg, is_br_next;
   logic taken_reg, taken_next;
   logic [31:0] pcn_reg, pcn_next;
   logic load_reg, load_next;
   logic [4:0] tidx_reg, tidx_next;
   logic [4:0] oidx_reg, oidx_next;
   logic slot_reg, slot_next;
   logic squash_reg, squash_next;
   logic misp_reg, misp_next;
   logic [3:0] cyc_reg, cyc_next;

   // Field picker: documented bit b counts from the msb, so it is word bit 31-b
   function automatic logic [5:0] opc_of(input logic [31:0] w);
      return w[CBU_OPC_HI:CBU_OPC_LO];
   endfunction

   // Only the four compare-against-zero conditions decode as branches
   function automatic logic cond_known(input logic [3:0] c);
      return (c >= CBU_COND_NE) && (c <= CBU_COND_GT);
   endfunction

   function automatic logic cond_true(input logic [3:0] c, input logic [31:0] v);
      logic neg;
      logic zero;
      neg = v[31];
      zero = (v == 32'h0000_0000);
      case (c)
         CBU_COND_GT: cond_true = !neg && !zero;
         CBU_COND_LE: cond_true = neg || zero;
         CBU_COND_LT: cond_true = neg;
         CBU_COND_NE: cond_true = !zero;
         default: cond_true = 1'b0;
      endcase
   endfunction

   // Keep the deep penalty inside its window whatever the parameter holds
   function automatic logic [3:0] deep_clamp(input logic [3:0] n);
      logic [3:0] r;
      r = n;
      if (n < CBU_LAT_MISPRED_AREA2_MIN) begin
         r = CBU_LAT_MISPRED_AREA2_MIN;
      end else if (n > CBU_LAT_MISPRED_AREA2_MAX) begin
         r = CBU_LAT_MISPRED_AREA2_MAX;
      end
      return r;
   endfunction

   // Occupancy of an accepted word; a forecast overrides it for the immediate form
   function automatic logic [3:0] lat_pick(input logic hit, input logic dly,
      input logic fcast, input logic fc_taken);
      logic [3:0] n;
      n = CBU_LAT_NOT_TAKEN;
      if (hit) begin
         n = dly ? CBU_LAT_TAKEN_DELAY : CBU_LAT_TAKEN_NODELAY;
      end
      if (fcast) begin
         if (fc_taken == hit) begin
            n = CBU_LAT_PRED_OK;
         end else if (AREA_OPTIMIZATION_SETTING == CBU_AREA_DEEP) begin
            // Deeper pipeline refills more stages after a wrong forecast
            n = deep_clamp(DEEP_MISPRED_CYCLES);
         end else begin
            n = CBU_LAT_MISPRED_AREA0;
         end
      end
      return n;
   endfunction

   logic [5:0] opc;
   logic dflag;
   logic [3:0] cond;
   logic dec_reg_form, dec_imm_form, dec_branch;
   logic [31:0] imm_ext, target, seq_pc;
   logic cond_ok, hit, fcast, accept;
   logic [3:0] lat;

   always_comb begin
      opc = opc_of(instr_word);
      dflag = instr_word[CBU_DELAY_BIT];
      cond = instr_word[CBU_COND_HI:CBU_COND_LO];
      dec_reg_form = (opc == CBU_OPC_REG) && cond_known(cond);
      dec_imm_form = (opc == CBU_OPC_IMM) && cond_known(cond);
      dec_branch = dec_reg_form || dec_imm_form;
      if (prefix_valid) begin
         imm_ext = {prefix_high, instr_word[CBU_IMM_HI:CBU_IMM_LO]};
      end else begin
         imm_ext = {{16{instr_word[CBU_IMM_HI]}}, instr_word[CBU_IMM_HI:CBU_IMM_LO]};
      end
      cond_ok = cond_true(cond, tested_register);
      hit = dec_branch && cond_ok;
      fcast = dec_imm_form && pred_valid;
      lat = lat_pick(hit, dflag, fcast, pred_taken);
      // A word is only taken in IDLE, so busy cycles never reach the decode
      accept = instr_valid && ready_reg && (state_reg == CBU_IDLE);
      seq_pc = pc_current + CBU_PC_STEP;
      if (dec_imm_form) begin
         target = pc_current + imm_ext;
      end else begin
         target = pc_current + offset_register;
      end
   end

   // Sequencing: holds instr_ready low for the busy cycles of a slow branch
   always_comb begin
      state_next = state_reg;
      wait_next = wait_reg;
      ready_next = ready_reg;
      case (state_reg)
         CBU_IDLE: begin
            // A correct forecast or an untaken branch with no forecast stays in IDLE
            if (accept && dec_branch && (lat > CBU_LAT_NOT_TAKEN)) begin
               wait_next = lat - 4'h1;
               ready_next = 1'b0;
               state_next = (hit && dflag) ? CBU_SLOT : CBU_BUSY;
            end
         end
         CBU_SLOT: begin
            // Slot instruction issues elsewhere while the target is fetched
            wait_next = wait_reg - 4'h1;
            if (wait_reg == 4'h1) begin
               ready_next = 1'b1;
               state_next = CBU_IDLE;
            end else begin
               state_next = CBU_BUSY;
            end
         end
         CBU_BUSY: begin
            wait_next = wait_reg - 4'h1;
            if (wait_reg == 4'h1) begin
               ready_next = 1'b1;
               state_next = CBU_IDLE;
            end
         end
         default: begin
            state_next = CBU_IDLE;
            wait_next = 4'h0;
            ready_next = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state_reg <= CBU_IDLE;
         wait_reg <= 4'h0;
         ready_reg <= 1'b1;
      end else begin
         state_reg <= state_next;
         wait_reg <= wait_next;
         ready_reg <= ready_next;
      end
   end

   // Result: decoded fields and next program counter of the accepted word
   always_comb begin
      is_br_next = is_br_reg;
      taken_next = taken_reg;
      pcn_next = pcn_reg;
      load_next = 1'b0;
      tidx_next = tidx_reg;
      oidx_next = oidx_reg;
      if (accept) begin
         // Non-branch words still report their fall-through address
         is_br_next = dec_branch;
         taken_next = hit;
         load_next = dec_branch;
         tidx_next = instr_word[CBU_TREG_HI:CBU_TREG_LO];
         oidx_next = instr_word[CBU_OREG_HI:CBU_OREG_LO];
         pcn_next = hit ? target : seq_pc;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         is_br_reg <= 1'b0;
         taken_reg <= 1'b0;
         pcn_reg <= CBU_PC_RESET;
         load_reg <= 1'b0;
         tidx_reg <= 5'h00;
         oidx_reg <= 5'h00;
      end else begin
         is_br_reg <= is_br_next;
         taken_reg <= taken_next;
         pcn_reg <= pcn_next;
         load_reg <= load_next;
         tidx_reg <= tidx_next;
         oidx_reg <= oidx_next;
      end
   end

   // Delay slot flags: each clears after the first SLOT or BUSY cycle, else holds until the next accepted word
   always_comb begin
      slot_next = slot_reg;
      squash_next = squash_reg;
      if (state_reg == CBU_SLOT) begin
         slot_next = 1'b0;
      end
      if (state_reg == CBU_BUSY) begin
         squash_next = 1'b0;
      end
      if (accept) begin
         slot_next = hit && dflag;
         squash_next = hit && !dflag;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         slot_reg <= 1'b0;
         squash_reg <= 1'b0;
      end else begin
         slot_reg <= slot_next;
         squash_reg <= squash_next;
      end
   end

   // Latency report and one-cycle mispredict pulse
   always_comb begin
      misp_next = 1'b0;
      cyc_next = cyc_reg;
      if (accept) begin
         misp_next = fcast && (pred_taken != hit);
         cyc_next = lat;
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         misp_reg <= 1'b0;
         cyc_reg <= 4'h0;
      end else begin
         misp_reg <= misp_next;
         cyc_reg <= cyc_next;
      end
   end

   // Every output comes straight from its register
   assign instr_ready = ready_reg;
   assign is_branch = is_br_reg;
   assign branch_taken = taken_reg;
   assign pc_next = pcn_reg;
   assign pc_load = load_reg;
   assign slot_execute = slot_reg;
   assign slot_squash = squash_reg;
   assign tested_index = tidx_reg;
   assign offset_index = oidx_reg;
   assign mispredict = misp_reg;
   assign branch_cycles = cyc_reg;
endmodule

// [include/cbu_pkg.sv]
// Package for the conditional branch unit: encodings, field positions, latencies
package cbu_pkg;
   localparam int CBU_XLEN = 32;
   localparam logic [5:0] CBU_OPC_REG = 6'h27;
   localparam logic [5:0] CBU_OPC_IMM = 6'h2f;
   localparam int CBU_OPC_HI = 31;
   localparam int CBU_OPC_LO = 26;
   localparam int CBU_DELAY_BIT = 25;
   localparam int CBU_COND_HI = 24;
   localparam int CBU_COND_LO = 21;
   localparam int CBU_TREG_HI = 20;
   localparam int CBU_TREG_LO = 16;
   localparam int CBU_OREG_HI = 15;
   localparam int CBU_OREG_LO = 11;
   localparam int CBU_IMM_HI = 15;
   localparam int CBU_IMM_LO = 0;
   localparam logic [3:0] CBU_COND_GT = 4'h4;
   localparam logic [3:0] CBU_COND_LE = 4'h3;
   localparam logic [3:0] CBU_COND_LT = 4'h2;
   localparam logic [3:0] CBU_COND_NE = 4'h1;
   localparam logic [31:0] CBU_PC_STEP = 32'h0000_0004;
   localparam logic [31:0] CBU_PC_RESET = 32'h0000_0000;
   localparam logic [3:0] CBU_LAT_NOT_TAKEN = 4'h1;
   localparam logic [3:0] CBU_LAT_TAKEN_DELAY = 4'h2;
   localparam logic [3:0] CBU_LAT_TAKEN_NODELAY = 4'h3;
   localparam logic [3:0] CBU_LAT_PRED_OK = 4'h1;
   localparam logic [3:0] CBU_LAT_MISPRED_AREA0 = 4'h3;
   localparam logic [3:0] CBU_LAT_MISPRED_AREA2_MIN = 4'h7;
   localparam logic [3:0] CBU_LAT_MISPRED_AREA2_MAX = 4'h9;
   localparam int CBU_AREA_FAST = 0;
   localparam int CBU_AREA_DEEP = 2;
   typedef enum logic [2:0] {
      CBU_IDLE = 3'b001,
      CBU_BUSY = 3'b010,
      CBU_SLOT = 3'b100
   } cbu_state_e;
endpackage

// [verif/cbu_branch_unit_chk.sv]
// Concurrent checks on the conditional branch unit ports
`timescale 1ns/100ps
module cbu_branch_unit_chk
   import cbu_pkg::*;
#(
   parameter int AREA_OPTIMIZATION_SETTING = 0
) (
   input wire logic clk_sys, // Clock
   input wire logic reset, // Reset
   input wire logic instr_valid, // In
   input wire logic [31:0] instr_word, // In
   input wire logic [31:0] pc_current, // In
   input wire logic [31:0] tested_register, // In
   input wire logic [31:0] offset_register, // In
   input wire logic prefix_valid, // In
   input wire logic [15:0] prefix_high, // In
   input wire logic pred_valid, // In
   input wire logic pred_taken, // In
   input wire logic instr_ready, // Out
   input wire logic is_branch, // Out
   input wire logic [31:0] pc_next, // Out
   input wire logic pc_load, // Out
   input wire logic slot_execute, // Out
   input wire logic slot_squash, // Out
   input wire logic mispredict, // Out
   input wire logic [3:0] branch_cycles // Out
);
   logic acc, imm, br, hit, pv, dly;
   logic [31:0] ext;
   always_comb begin
      imm = instr_word[31:26] == CBU_OPC_IMM;
      br = (imm || instr_word[31:26] == CBU_OPC_REG) && instr_word[24:21] inside {[4'h1:4'h4]};
      acc = instr_valid && instr_ready && br;
      dly = instr_word[25];
      pv = imm && pred_valid;
      case (instr_word[24:21])
         CBU_COND_GT: hit = $signed(tested_register) > 0;
         CBU_COND_LE: hit = $signed(tested_register) <= 0;
         CBU_COND_LT: hit = $signed(tested_register) < 0;
         default: hit = tested_register != 32'h0;
      endcase
      ext = {prefix_valid ? prefix_high : {16{instr_word[15]}}, instr_word[15:0]};
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   sequence s_busy1;
      !instr_ready ##1 instr_ready;
   endsequence
   sequence s_busy2;
      !instr_ready ##1 s_busy1;
   endsequence
   a_branch_loads_pc: assert property (acc |=> pc_load && is_branch)
      else $error("branch did not load pc");
   a_other_no_load: assert property (instr_valid && instr_ready && !br |=> !pc_load && !is_branch)
      else $error("non-branch loaded pc");
   a_untaken_step: assert property (acc && !hit && !pv |=>
      pc_next == $past(pc_current) + CBU_PC_STEP && branch_cycles == CBU_LAT_NOT_TAKEN && instr_ready)
      else $error("untaken branch wrong");
   a_reg_target: assert property (acc && !imm && hit |=> pc_next == $past(pc_current + offset_register))
      else $error("register target wrong");
   a_imm_target: assert property (acc && imm && hit |=> pc_next == $past(pc_current + ext))
      else $error("immediate target wrong");
   a_delay_slot_run: assert property (acc && hit && dly && !pv |=>
      (slot_execute && !slot_squash && branch_cycles == CBU_LAT_TAKEN_DELAY) ##0 s_busy1)
      else $error("delayed branch wrong");
   a_nodelay_squash: assert property (acc && hit && !dly && !pv |=>
      (slot_squash && !slot_execute && branch_cycles == CBU_LAT_TAKEN_NODELAY) ##0 s_busy2)
      else $error("undelayed branch wrong");
   a_pred_ok_fast: assert property (acc && pv && pred_taken == hit |=> !mispredict
      && branch_cycles == CBU_LAT_PRED_OK)
      else $error("correct forecast wrong");
   a_mispred_slow: assert property (acc && pv && pred_taken != hit
      && AREA_OPTIMIZATION_SETTING == 0 |=> mispredict && branch_cycles == CBU_LAT_MISPRED_AREA0)
      else $error("mispredict wrong");
   a_mispred_deep: assert property (acc && pv && pred_taken != hit
      && AREA_OPTIMIZATION_SETTING == 2 |=> mispredict && branch_cycles >= CBU_LAT_MISPRED_AREA2_MIN
      && branch_cycles <= CBU_LAT_MISPRED_AREA2_MAX)
      else $error("deep mispredict wrong");
endmodule
bind cbu_branch_unit cbu_branch_unit_chk #(.AREA_OPTIMIZATION_SETTING(AREA_OPTIMIZATION_SETTING)) i_chk (
   .clk_sys, .reset, .instr_valid, .instr_word, .pc_current, .tested_register, .offset_register,
   .prefix_valid, .prefix_high, .pred_valid, .pred_taken, .instr_ready, .is_branch, .pc_next,
   .pc_load, .slot_execute, .slot_squash, .mispredict, .branch_cycles);

// [verif/cbu_branch_unit_bench.sv]
// Self-checking bench for the conditional branch unit
`timescale 1ns/100ps
module cbu_branch_unit_bench
   import cbu_pkg::*;
();
   logic clk_sys = 1'b0, reset = 1'b1, instr_valid = 1'b0, prefix_valid = 1'b0;
   logic pred_valid = 1'b0, pred_taken = 1'b0, instr_ready, is_branch, branch_taken;
   logic pc_load, slot_execute, slot_squash, mispredict;
   logic [31:0] instr_word = 32'h0, pc_current = 32'h1000, tested_register = 32'h0;
   logic [31:0] offset_register = 32'h0, pc_next;
   logic [15:0] prefix_high = 16'h0;
   logic [4:0] tested_index, offset_index;
   logic [3:0] branch_cycles;
   logic mispredict_deep;
   logic [3:0] branch_cycles_deep;
   int failures = 0, n_tests = 0, cyc = 0;
   always #2.5 clk_sys = ~clk_sys;
   cbu_branch_unit i_dut (.clk_sys, .reset, .instr_valid, .instr_word, .pc_current,
      .tested_register, .offset_register, .prefix_valid, .prefix_high, .pred_valid, .pred_taken,
      .instr_ready, .is_branch, .branch_taken, .pc_next, .pc_load, .slot_execute, .slot_squash,
      .tested_index, .offset_index, .mispredict, .branch_cycles);
   cbu_branch_unit #(.AREA_OPTIMIZATION_SETTING(CBU_AREA_DEEP)) i_dut_deep (.clk_sys, .reset,
      .instr_valid, .instr_word, .pc_current, .tested_register, .offset_register, .prefix_valid,
      .prefix_high, .pred_valid, .pred_taken, .instr_ready(), .is_branch(), .branch_taken(),
      .pc_next(), .pc_load(), .slot_execute(), .slot_squash(), .tested_index(), .offset_index(),
      .mispredict(mispredict_deep), .branch_cycles(branch_cycles_deep));
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic issue(logic [5:0] op, logic d, logic [3:0] c, logic [31:0] tv, logic [31:0] lo);
      for (int n = 0; n < 20 && instr_ready !== 1'b1; n++) begin
         @(posedge clk_sys);
         #1;
      end
      instr_word = {op, d, c, 5'h03, lo[15:0]};
      tested_register = tv;
      offset_register = lo;
      instr_valid = 1'b1;
      @(posedge clk_sys);
      #1;
      instr_valid = 1'b0;
   endtask
   function automatic logic exp_hit(logic [3:0] c, logic signed [31:0] v);
      case (c)
         CBU_COND_GT: return v > 0;
         CBU_COND_LE: return v <= 0;
         CBU_COND_LT: return v < 0;
         default: return v != 0;
      endcase
   endfunction
   task automatic t_conds;
      logic [31:0] vals [4] = '{32'hffff_fffb, 32'h0, 32'h7, 32'h8000_0000};
      logic h;
      for (int c = 1; c < 5; c++) begin
         foreach (vals[i]) begin
            h = exp_hit(c[3:0], vals[i]);
            issue(CBU_OPC_REG, 1'b1, c[3:0], vals[i], 32'h0000_2840);
            chk("branch_taken", h, branch_taken);
            chk("pc_next", h ? 32'h3840 : 32'h1004, pc_next);
            chk("branch_cycles", h ? 2 : 1, branch_cycles);
            chk("pc_load", 1, pc_load);
            chk("offset_index", 5'h05, offset_index);
            chk("tested_index", 5'h03, tested_index);
         end
      end
      $display("conditions test done");
   endtask
   task automatic t_slots;
      for (int d = 0; d < 2; d++) begin
         issue(CBU_OPC_REG, d[0], CBU_COND_NE, 32'h1, 32'h0000_0100);
         chk("slot_execute", d, slot_execute);
         chk("slot_squash", !d, slot_squash);
         chk("branch_cycles", d ? 2 : 3, branch_cycles);
         for (int i = 1; i < (d ? 2 : 3); i++) begin
            chk("instr_ready", 0, instr_ready);
            @(posedge clk_sys);
            #1;
         end
         chk("instr_ready", 1, instr_ready);
      end
      $display("delay slot test done");
   endtask
   task automatic t_imm;
      issue(CBU_OPC_IMM, 1'b1, CBU_COND_NE, 32'h1, 32'h0000_fff0);
      chk("pc_next", 32'h0000_0ff0, pc_next);
      prefix_valid = 1'b1;
      prefix_high = 16'h0001;
      issue(CBU_OPC_IMM, 1'b1, CBU_COND_NE, 32'h1, 32'h0000_fff0);
      chk("pc_next", 32'h0002_0ff0, pc_next);
      prefix_valid = 1'b0;
      $display("immediate test done");
   endtask
   task automatic t_pred;
      pred_valid = 1'b1;
      for (int p = 0; p < 2; p++) begin
         pred_taken = !p;
         issue(CBU_OPC_IMM, 1'b0, CBU_COND_GT, 32'h1, 32'h0000_0010);
         chk("mispredict", p, mispredict);
         chk("branch_cycles", p ? 3 : 1, branch_cycles);
         chk("mispredict_deep", p, mispredict_deep);
         chk("branch_cycles_deep", p ? CBU_LAT_MISPRED_AREA2_MAX : CBU_LAT_PRED_OK, branch_cycles_deep);
      end
      pred_valid = 1'b0;
      $display("prediction test done");
   endtask
   task automatic t_other;
      issue(6'h00, 1'b0, CBU_COND_NE, 32'h1, 32'h0);
      chk("is_branch", 0, is_branch);
      issue(CBU_OPC_REG, 1'b0, 4'h0, 32'h1, 32'h0);
      chk("pc_load", 0, pc_load);
      $display("non-branch test done");
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         end_sim();
      end
   end
   initial begin
      repeat (2) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      t_conds();
      t_slots();
      t_imm();
      t_pred();
      t_other();
      end_sim();
   end
endmodule
